// >>> dsou_pkg.sv
package dsou_pkg;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [15:0] ADDR_CTL = 16'h02e8;
  localparam logic [15:0] ADDR_STAT = 16'h02ec;
  localparam logic [15:0] ADDR_CNT = 16'h02f0;
  localparam logic [15:0] ADDR_IRQ = 16'h02f4;
  localparam logic [15:0] ADDR_MASK = 16'h02f8;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTL_ENA = 0;
  localparam int CTL_SRST = 1;
  localparam int CTL_MODE = 2;
  localparam int CTL_START = 3;
  localparam int CTL_CLRPL = 4;
  localparam int CTL_SRC = 5;
  localparam int STAT_BUSY = 0;
  localparam int STAT_LOADED = 1;
  localparam int STAT_TERR = 5;
  localparam int STAT_FERR = 6;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_TERR = 1;
  localparam int IRQ_FERR = 2;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] CNT_RST = 16'h0001;
  localparam logic [2:0] MASK_RST = 3'h0;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 25000;
  localparam int LOAD_LOW_NS = 50;
  localparam int LOAD_LOW_RAW = (LOAD_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0] LOAD_LOW_CYC = 4'((LOAD_LOW_RAW < 1) ? 1 : LOAD_LOW_RAW);

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    DSOU_IDLE = 2'b00,
    DSOU_BURST = 2'b01,
    DSOU_HALT = 2'b10
  } dsou_state_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [15:0] adr;
    logic [31:0] dat;
  } dsou_wb_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] idx;
    logic [15:0] data;
  } dsou_dac_wr_t;

endpackage : dsou_pkg

// >>> dsou_sync.sv
`timescale 1ns/1ps
module dsou_sync #(
  parameter int W = 3
) (
  input logic clock,
  input logic rst,
  input logic [W-1:0] din,
  output logic [W-1:0] level
);

  // ----------------------------------------
  // Three stages; level moves once stages two and three agree
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_ff, s2_ff, s3_ff, lvl_ff;
      always_ff @(posedge clock) begin
        if (rst) begin
          s1_ff <= 1'b0;
          s2_ff <= 1'b0;
          s3_ff <= 1'b0;
          lvl_ff <= 1'b0;
        end else begin
          s1_ff <= din[i];
          s2_ff <= s1_ff;
          s3_ff <= s2_ff;
          if (s2_ff == s3_ff) begin
            lvl_ff <= s3_ff;
          end
        end
      end
      assign level[i] = lvl_ff;
    end
  endgenerate

endmodule : dsou_sync

// >>> dsou_top.sv
// What this block does
// RULE1: Writing pre-load clear marks all DACs unloaded; the bit reads back zero.
// RULE2: Unloaded DACs refill automatically once FIFO data is present.
// RULE3: Writing start launches a Normal-mode burst; the bit reads back zero.
// RULE4: Software enables the unit before writing start.
// RULE5: Software may check FIFO level before starting.
// RULE6: Mode bit: 0 Normal, 1 Frame; read/write, resets to 0.
// RULE7: Normal mode: burst of set length from first conversion clock edge after start.
// RULE8: Frame mode: burst of set length from next conversion edge after each trigger.
// RULE9: Soft reset clears internal state, keeps registers; bit reads back zero.
// RULE10: Enable bit switches unit on or off; resets to 0.
// RULE11: Unit moves data to DACs and drives active-low load strobe.
// RULE12: Enabled and not fully loaded, move FIFO data into DACs, unless in error.
// RULE13: On error, stop transfers and load strobes.
// RULE14: After error, software reads status, then disables.
// RULE15: Clearing enable resets the internal state.
// RULE16: Trigger before burst completes sets frame error, aborts and stops.
// RULE17: Conversion edge violating DAC timing sets timing error, aborts and stops.
// RULE18: In Frame mode the conversion clock is phase locked to the trigger.
// RULE19: Start while disabled or in Frame mode has no effect.
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
module dsou_top #(
  parameter int DAC_WORDS = 16
) (
  input logic clock,
  input logic rst,
  input dsou_pkg::dsou_wb_req_t wb_req,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input logic fifo_valid,
  input logic [15:0] fifo_data,
  output logic fifo_ready,
  input logic conv_clk1,
  input logic conv_clk2,
  input logic frame_trig,
  output dsou_pkg::dsou_dac_wr_t dac_wr,
  output logic dac_load_strobe_n,
  output logic irq
);

  localparam int LW = $clog2(DAC_WORDS + 1);
  localparam logic [LW-1:0] FULL = LW'(DAC_WORDS);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic output_unit_enable_ff, output_unit_mode_select_ff, src_ff;
  logic [15:0] count_ff, remain_ff, nxt_remain;
  logic [2:0] irq_st_ff, mask_ff, nxt_irq_st;
  logic conversion_timing_error_ff, frame_overrun_error_ff;
  dsou_pkg::dsou_state_t state_ff, nxt_state;
  logic [LW-1:0] ld_ff, nxt_ld;
  logic rdy_ff, nxt_rdy;
  dsou_pkg::dsou_dac_wr_t dac_wr_ff;
  logic [3:0] low_ff, nxt_low;
  logic dac_load_strobe_n_n_ff, ack_ff, irq_ff;
  logic [31:0] rdat_ff, rd_word;
  logic conv_d_ff, frm_d_ff;
  logic [2:0] pin_lvl;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire acc = wb_req.cyc & wb_req.stb & ~ack_ff;
  wire wr = acc & wb_req.we;
  wire rd = acc & ~wb_req.we;
  wire [13:0] widx = wb_req.adr[15:2];
  wire hit_ctl = widx == dsou_pkg::ADDR_CTL[15:2];
  wire hit_stat = widx == dsou_pkg::ADDR_STAT[15:2];
  wire hit_cnt = widx == dsou_pkg::ADDR_CNT[15:2];
  wire hit_irq = widx == dsou_pkg::ADDR_IRQ[15:2];
  wire hit_mask = widx == dsou_pkg::ADDR_MASK[15:2];
  wire wr_ctl = wr & hit_ctl & wb_req.sel[0];
  wire irq_clr = rd & hit_irq;

  // ----------------------------------------
  // Control strobes
  // ----------------------------------------
  wire w_ena = wr_ctl ? wb_req.dat[dsou_pkg::CTL_ENA] : output_unit_enable_ff;
  wire output_unit_soft_reset = wr_ctl & wb_req.dat[dsou_pkg::CTL_SRST]; // [RULE9]
  wire preload_status_clear = wr_ctl & wb_req.dat[dsou_pkg::CTL_CLRPL]; // [RULE1]
  wire err = conversion_timing_error_ff | frame_overrun_error_ff;
  // Internal state is held cleared while disabled or on soft reset
  wire kill = ~output_unit_enable_ff | output_unit_soft_reset; // [RULE15] [RULE9]
  wire live = output_unit_enable_ff & ~err;
  wire bursting = state_ff == dsou_pkg::DSOU_BURST;
  // Start only counts when already enabled and in Normal mode
  wire normal_conversion_start = wr_ctl & wb_req.dat[dsou_pkg::CTL_START] & live & ~output_unit_mode_select_ff; // [RULE4] [RULE19]

  // ----------------------------------------
  // Pin inputs
  // ----------------------------------------
  dsou_sync #(
    .W(3)
  ) u_sync (
    .clock(clock),
    .rst(rst),
    .din({frame_trig, conv_clk2, conv_clk1}),
    .level(pin_lvl)
  );

  wire conv_lvl = src_ff ? pin_lvl[1] : pin_lvl[0];
  wire conv_evt = conv_lvl & ~conv_d_ff;
  wire frame_evt = pin_lvl[2] & ~frm_d_ff;

  // ----------------------------------------
  // Conversion core
  // ----------------------------------------
  wire loaded = ld_ff == FULL;
  wire strobing = low_ff != 4'h0;
  wire take = fifo_valid & rdy_ff; // [RULE12]
  wire fire = live & bursting & conv_evt & loaded & ~strobing; // [RULE7] [RULE8]
  wire t_viol = live & bursting & conv_evt & (~loaded | strobing); // [RULE17]
  wire f_viol = live & output_unit_mode_select_ff & bursting & frame_evt; // [RULE16]
  wire f_arm = live & output_unit_mode_select_ff & ~bursting & frame_evt; // [RULE8]
  wire last = fire & (remain_ff == 16'h0001);
  wire viol = t_viol | f_viol;
  wire nxt_err = ~kill & (err | viol);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      dsou_pkg::DSOU_IDLE: begin
        if ((normal_conversion_start | f_arm) & (count_ff != 16'h0000)) begin
          nxt_state = dsou_pkg::DSOU_BURST; // [RULE3] [RULE8]
        end
      end
      dsou_pkg::DSOU_BURST: begin
        if (viol) begin
          nxt_state = dsou_pkg::DSOU_HALT; // [RULE16] [RULE17]
        end else if (last) begin
          nxt_state = dsou_pkg::DSOU_IDLE;
        end
      end
      default: begin
        nxt_state = dsou_pkg::DSOU_HALT;
      end
    endcase
    if (kill) begin
      nxt_state = dsou_pkg::DSOU_IDLE;
    end
  end

  assign nxt_remain = (kill | viol) ? 16'h0000 :
                      (nxt_state == dsou_pkg::DSOU_BURST && !bursting) ? count_ff :
                      fire ? remain_ff - 16'h0001 : remain_ff;

  // Conversion consumes the loaded set; clear forgets it
  assign nxt_ld = (kill | preload_status_clear | fire) ? '0 : take ? ld_ff + LW'(1) : ld_ff; // [RULE1]

  // Refill whenever enabled, error free and short of a full set
  assign nxt_rdy = w_ena & ~kill & ~nxt_err & (nxt_ld < FULL); // [RULE2] [RULE12] [RULE13]

  // Error stops a strobe in flight
  assign nxt_low = (kill | viol) ? 4'h0 : fire ? dsou_pkg::LOAD_LOW_CYC : strobing ? low_ff - 4'h1 : 4'h0; // [RULE13]

  assign nxt_irq_st = (irq_clr ? 3'h0 : irq_st_ff) | {f_viol, t_viol, last};

  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff <= dsou_pkg::DSOU_IDLE;
      remain_ff <= 16'h0000;
      ld_ff <= '0;
      rdy_ff <= 1'b0;
      low_ff <= 4'h0;
      dac_load_strobe_n_n_ff <= 1'b1;
      dac_wr_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      remain_ff <= nxt_remain;
      ld_ff <= nxt_ld;
      rdy_ff <= nxt_rdy;
      low_ff <= nxt_low;
      dac_load_strobe_n_n_ff <= nxt_low == 4'h0; // [RULE11]
      dac_wr_ff.valid <= take; // [RULE11]
      dac_wr_ff.idx <= 8'(ld_ff);
      dac_wr_ff.data <= fifo_data;
    end
  end

  // ----------------------------------------
  // Error flags and pin edges
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      conversion_timing_error_ff <= 1'b0;
      frame_overrun_error_ff <= 1'b0;
      conv_d_ff <= 1'b0;
      frm_d_ff <= 1'b0;
    end else begin
      conversion_timing_error_ff <= ~kill & (conversion_timing_error_ff | t_viol); // [RULE17]
      frame_overrun_error_ff <= ~kill & (frame_overrun_error_ff | f_viol); // [RULE16]
      conv_d_ff <= conv_lvl;
      frm_d_ff <= pin_lvl[2];
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      output_unit_enable_ff <= 1'b0; // [RULE10]
      output_unit_mode_select_ff <= 1'b0; // [RULE6]
      src_ff <= 1'b0;
      count_ff <= dsou_pkg::CNT_RST;
      mask_ff <= dsou_pkg::MASK_RST;
      irq_st_ff <= 3'h0;
      irq_ff <= 1'b0;
    end else begin
      if (wr_ctl) begin
        output_unit_enable_ff <= wb_req.dat[dsou_pkg::CTL_ENA]; // [RULE10]
        output_unit_mode_select_ff <= wb_req.dat[dsou_pkg::CTL_MODE]; // [RULE6]
        src_ff <= wb_req.dat[dsou_pkg::CTL_SRC];
      end
      if (wr & hit_cnt & wb_req.sel[0]) begin
        count_ff[7:0] <= wb_req.dat[7:0];
      end
      if (wr & hit_cnt & wb_req.sel[1]) begin
        count_ff[15:8] <= wb_req.dat[15:8];
      end
      if (wr & hit_mask & wb_req.sel[0]) begin
        mask_ff <= wb_req.dat[2:0];
      end
      irq_st_ff <= nxt_irq_st;
      irq_ff <= |(nxt_irq_st & mask_ff);
    end
  end

  // ----------------------------------------
  // Bus answer
  // ----------------------------------------
  // Self-clearing controls always read as zero
  assign rd_word = hit_ctl ? {26'h0, src_ff, 2'h0, output_unit_mode_select_ff, 1'b0, output_unit_enable_ff} :
                   hit_stat ? {25'h0, frame_overrun_error_ff, conversion_timing_error_ff, 3'h0, loaded, bursting} :
                   hit_cnt ? {16'h0, count_ff} :
                   hit_irq ? {29'h0, irq_st_ff} :
                   hit_mask ? {29'h0, mask_ff} : 32'h0;

  always_ff @(posedge clock) begin
    if (rst) begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0;
    end else begin
      ack_ff <= acc;
      if (rd) begin
        rdat_ff <= rd_word;
      end
    end
  end

  assign wb_dat_o = rdat_ff;
  assign wb_ack_o = ack_ff;
  assign fifo_ready = rdy_ff;
  assign dac_wr = dac_wr_ff;
  assign dac_load_strobe_n = dac_load_strobe_n_n_ff;
  assign irq = irq_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence s_start;
    normal_conversion_start & ~output_unit_soft_reset & (state_ff == dsou_pkg::DSOU_IDLE) & (count_ff != 16'h0000);
  endsequence

  sequence s_fire;
    fire & ~output_unit_soft_reset & ~f_viol;
  endsequence

  sequence s_strobe_two;
    !dac_load_strobe_n ##1 (!dac_load_strobe_n | $past(kill | viol)) ##1 dac_load_strobe_n;
  endsequence

  a_reset_values: assert property ( // [RULE6] [RULE10]
    $past(rst) |-> !output_unit_mode_select_ff && !output_unit_enable_ff)
    else $error("mode or enable not zero after reset");

  a_start_arms: assert property ( // [RULE3]
    s_start |=> bursting && remain_ff == $past(count_ff))
    else $error("start did not arm a burst");

  a_start_ignored: assert property ( // [RULE19]
    wr_ctl & wb_req.dat[dsou_pkg::CTL_START] & (output_unit_mode_select_ff | ~output_unit_enable_ff)
      & ~bursting & ~f_arm |=> !bursting)
    else $error("ignored start launched a burst");

  a_fire_strobe: assert property ( // [RULE7]
    s_fire |=> !dac_load_strobe_n_n_ff ##0 remain_ff == $past(remain_ff) - 16'h0001)
    else $error("conversion edge gave no strobe");

  a_strobe_width: assert property ( // [RULE11]
    s_fire |=> s_strobe_two)
    else $error("load strobe width wrong");

  a_done_irq: assert property ( // [RULE7]
    last |=> irq_st_ff[dsou_pkg::IRQ_DONE])
    else $error("burst end not recorded");

  a_error_irq: assert property ( // [RULE16] [RULE17]
    f_viol | t_viol |=> irq_st_ff[dsou_pkg::IRQ_FERR] | irq_st_ff[dsou_pkg::IRQ_TERR])
    else $error("error event not recorded");

  a_frame_arm: assert property ( // [RULE8]
    f_arm & (count_ff != 16'h0000) & ~output_unit_soft_reset |=> bursting && remain_ff == $past(count_ff))
    else $error("trigger did not arm a burst");

  a_clear_preload: assert property ( // [RULE1]
    preload_status_clear |=> ld_ff == '0)
    else $error("pre-load clear ignored");

  a_self_clear: assert property ( // [RULE1] [RULE3] [RULE9]
    rd & hit_ctl |=> wb_dat_o[4:3] == 2'h0 && !wb_dat_o[1])
    else $error("self-clearing bit read as one");

  a_refill_ready: assert property ( // [RULE2]
    output_unit_enable_ff & ~err & ~wr_ctl & (ld_ff == '0) & ~viol |=> fifo_ready)
    else $error("no refill while unloaded");

  a_take_writes: assert property ( // [RULE12]
    take |=> dac_wr.valid && dac_wr.data == $past(fifo_data))
    else $error("taken word not written to DAC");

  a_error_quiet: assert property ( // [RULE13]
    err |-> dac_load_strobe_n && !fifo_ready ##1 !dac_wr.valid)
    else $error("activity during error");

  a_frame_error: assert property ( // [RULE16]
    f_viol & ~output_unit_soft_reset |=> frame_overrun_error_ff && !bursting && remain_ff == 16'h0000)
    else $error("early trigger not flagged");

  a_timing_error: assert property ( // [RULE17]
    t_viol & ~output_unit_soft_reset |=> conversion_timing_error_ff && dac_load_strobe_n && !bursting)
    else $error("timing violation not flagged");

  a_disable_clear: assert property ( // [RULE15]
    !output_unit_enable_ff |=> !err && !bursting && ld_ff == '0)
    else $error("disable left state");

  a_soft_reset: assert property ( // [RULE9]
    output_unit_soft_reset |=> !bursting && ld_ff == '0 && count_ff == $past(count_ff))
    else $error("soft reset wrong");

endmodule : dsou_top

// >>> dsou_dac_model.sv
`timescale 1ns/1ps
module dsou_dac_model (
  input logic clock,
  input logic rst,
  input dsou_pkg::dsou_dac_wr_t dac_wr,
  input logic dac_load_strobe_n,
  output logic [15:0] n_words_ff,
  output logic [15:0] n_loads_ff,
  output logic [7:0] last_idx_ff,
  output logic bad_width_ff
);
  logic strobe_d_ff;
  logic [3:0] low_cnt_ff;

  // ----------------------------------------
  // Word capture and load strobe counting
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      n_words_ff <= 16'h0000;
      n_loads_ff <= 16'h0000;
      last_idx_ff <= 8'h00;
      bad_width_ff <= 1'b0;
      strobe_d_ff <= 1'b1;
      low_cnt_ff <= 4'h0;
    end else begin
      strobe_d_ff <= dac_load_strobe_n;
      if (dac_wr.valid) begin
        n_words_ff <= n_words_ff + 16'h0001;
        last_idx_ff <= dac_wr.idx;
      end
      low_cnt_ff <= dac_load_strobe_n ? 4'h0 : low_cnt_ff + 4'h1;
      if (strobe_d_ff && !dac_load_strobe_n) begin
        n_loads_ff <= n_loads_ff + 16'h0001;
      end
      // A load pulse shorter or longer than the set low time is flagged
      if (dac_load_strobe_n && !strobe_d_ff && low_cnt_ff != dsou_pkg::LOAD_LOW_CYC) begin
        bad_width_ff <= 1'b1;
      end
    end
  end
endmodule : dsou_dac_model

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam int NW = 4;
  logic clock = 1'b0;
  logic rst = 1'b1;
  dsou_pkg::dsou_wb_req_t wb_req = '0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, fifo_ready, dac_load_strobe_n, irq, bad_width;
  logic fifo_valid = 1'b0;
  logic [15:0] fifo_data = 16'h0000;
  logic conv_clk1 = 1'b0;
  logic conv_clk2 = 1'b0;
  logic frame_trig = 1'b0;
  dsou_pkg::dsou_dac_wr_t dac_wr;
  logic [15:0] n_words, n_loads;
  logic [7:0] last_idx;
  logic [31:0] rd;
  int num_errors = 0;
  int n_checks = 0;
  int exp_words = 0;
  int exp_loads = 0;

  always #12.5 clock = ~clock;

  always @(posedge clock) begin
    if (fifo_valid && fifo_ready) fifo_data <= fifo_data + 16'h0001;
  end

  dsou_top #(.DAC_WORDS(NW)) dsou_top_i (.clock(clock), .rst(rst), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .fifo_valid(fifo_valid), .fifo_data(fifo_data), .fifo_ready(fifo_ready),
    .conv_clk1(conv_clk1), .conv_clk2(conv_clk2), .frame_trig(frame_trig), .dac_wr(dac_wr),
    .dac_load_strobe_n(dac_load_strobe_n), .irq(irq));
  dsou_dac_model dsou_dac_model_i (.clock(clock), .rst(rst), .dac_wr(dac_wr), .dac_load_strobe_n(dac_load_strobe_n),
    .n_words_ff(n_words), .n_loads_ff(n_loads), .last_idx_ff(last_idx), .bad_width_ff(bad_width));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic close_out;
    if (num_errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : check

  task automatic bus(input logic we, input logic [15:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clock);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: adr, dat: dat};
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
    rd = wb_dat_o;
    wb_req <= '0;
  endtask : bus

  task automatic wr(input logic [15:0] adr, input logic [31:0] dat);
    bus(1'b1, adr, dat);
  endtask : wr

  task automatic rdchk(input string name, input logic [15:0] adr, input logic [31:0] exp);
    bus(1'b0, adr, 32'h0);
    check(name, rd, exp);
  endtask : rdchk

  task automatic settle(input int words);
    exp_words += words;
    repeat (200) begin
      @(posedge clock);
      if (n_words == exp_words) break;
    end
    check("dac words", 32'(n_words), 32'(exp_words));
  endtask : settle

  task automatic loads(input int k);
    exp_loads += k;
    check("load strobes", 32'(n_loads), 32'(exp_loads));
  endtask : loads

  task automatic pulse(input logic [1:0] which);
    @(posedge clock);
    if (which == 2'h1) frame_trig <= 1'b1;
    else if (which == 2'h2) conv_clk2 <= 1'b1;
    else conv_clk1 <= 1'b1;
    repeat (6) @(posedge clock);
    frame_trig <= 1'b0;
    conv_clk1 <= 1'b0;
    conv_clk2 <= 1'b0;
    repeat (8) @(posedge clock);
  endtask : pulse

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_values;
    check("strobe idle", 32'(dac_load_strobe_n), 32'h1);
    check("fifo ready", 32'(fifo_ready), 32'h0);
    rdchk("control", dsou_pkg::ADDR_CTL, 32'h0);
    rdchk("count", dsou_pkg::ADDR_CNT, 32'(dsou_pkg::CNT_RST));
    rdchk("mask", dsou_pkg::ADDR_MASK, 32'(dsou_pkg::MASK_RST));
    wr(16'h0300, 32'hffffffff);
    rdchk("unmapped", 16'h0300, 32'h0);
    wr(dsou_pkg::ADDR_CTL, 32'h4);
    rdchk("mode", dsou_pkg::ADDR_CTL, 32'h4);
    wr(dsou_pkg::ADDR_CTL, 32'h0);
  endtask : t_reset_values

  task automatic t_normal;
    wr(dsou_pkg::ADDR_CNT, 32'h2);
    wr(dsou_pkg::ADDR_CTL, 32'h1);
    fifo_valid <= 1'b1;
    settle(NW);
    check("last index", 32'(last_idx), 32'(NW - 1));
    rdchk("loaded", dsou_pkg::ADDR_STAT, 32'h2);
    wr(dsou_pkg::ADDR_CTL, 32'h9);
    rdchk("start clears", dsou_pkg::ADDR_CTL, 32'h1);
    pulse(1'b0);
    loads(1);
    settle(NW);
    pulse(1'b0);
    loads(1);
    settle(NW);
    pulse(1'b0);
    loads(0);
    check("irq masked", 32'(irq), 32'h0);
    wr(dsou_pkg::ADDR_MASK, 32'h1);
    repeat (2) @(posedge clock);
    check("irq raised", 32'(irq), 32'h1);
    rdchk("irq status", dsou_pkg::ADDR_IRQ, 32'h1);
    repeat (2) @(posedge clock);
    check("irq cleared", 32'(irq), 32'h0);
  endtask : t_normal

  task automatic t_frame;
    wr(dsou_pkg::ADDR_CTL, 32'h0);
    rdchk("status off", dsou_pkg::ADDR_STAT, 32'h0);
    wr(dsou_pkg::ADDR_CTL, 32'h9);
    settle(NW);
    pulse(1'b0);
    loads(0);
    wr(dsou_pkg::ADDR_CTL, 32'h5);
    wr(dsou_pkg::ADDR_CTL, 32'hd);
    pulse(1'b0);
    loads(0);
    pulse(1'b1);
    pulse(1'b0);
    loads(1);
    settle(NW);
    pulse(1'b1);
    bus(1'b0, dsou_pkg::ADDR_STAT, 32'h0);
    check("frame error", rd & 32'h40, 32'h40);
    pulse(1'b0);
    loads(0);
    wr(dsou_pkg::ADDR_CTL, 32'h0);
    rdchk("frame error off", dsou_pkg::ADDR_STAT, 32'h0);
  endtask : t_frame

  task automatic t_timing_error;
    wr(dsou_pkg::ADDR_CTL, 32'h1);
    settle(NW);
    fifo_valid <= 1'b0;
    wr(dsou_pkg::ADDR_CTL, 32'h11);
    rdchk("clear reads 0", dsou_pkg::ADDR_CTL, 32'h1);
    rdchk("unloaded", dsou_pkg::ADDR_STAT, 32'h0);
    wr(dsou_pkg::ADDR_CTL, 32'h9);
    pulse(1'b0);
    loads(0);
    bus(1'b0, dsou_pkg::ADDR_STAT, 32'h0);
    check("timing error", rd & 32'h20, 32'h20);
    rdchk("irq errors", dsou_pkg::ADDR_IRQ, 32'h6);
    fifo_valid <= 1'b1;
    repeat (10) @(posedge clock);
    settle(0);
    wr(dsou_pkg::ADDR_CTL, 32'h3);
    rdchk("soft reset keeps", dsou_pkg::ADDR_CTL, 32'h1);
    settle(NW);
    rdchk("after soft reset", dsou_pkg::ADDR_STAT, 32'h2);
    wr(dsou_pkg::ADDR_CTL, 32'h29);
    rdchk("source", dsou_pkg::ADDR_CTL, 32'h21);
    pulse(2'h0);
    loads(0);
    pulse(2'h2);
    loads(1);
  endtask : t_timing_error

  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    t_reset_values;
    t_normal;
    t_frame;
    t_timing_error;
    check("load width", 32'(bad_width), 32'h0);
    close_out;
  end

  initial begin
    #(25 * 20000);
    num_errors++;
    close_out;
  end
endmodule : testbench
